// File: rtl/fsc_core.sv
// Speed command meter, drive PWM, soft start, tach divider, phase trim and
// start/stop sequencer of the fan driver.
// Assumes ref_clk at 40 MHz, reset released when supply lockout or sleep clears.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fsc_core
  import fsc_pkg::*;
#(
  parameter int unsigned INIT_CYCLES  = fsc_pkg::INIT_CYC,
  parameter int unsigned LOCK_SHORT   = fsc_pkg::LOCK_SHORT_CYC,
  parameter int unsigned LOCK_LONG    = fsc_pkg::LOCK_LONG_CYC,
  parameter int unsigned RETRY_SHORT  = fsc_pkg::RETRY_SHORT_CYC,
  parameter int unsigned RETRY_LONG   = fsc_pkg::RETRY_LONG_CYC,
  parameter int unsigned HALL_SLOW    = fsc_pkg::HALL_SLOW_CYC,
  parameter int unsigned PER_W        = 16
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // Pins
  input  wire logic                        speed_command_input,
  input  wire logic                        hall_compare,
  input  wire logic                        sleep_request,
  input  wire logic                        uvlo_active,
  input  wire logic                        phase_shift_select,
  input  wire logic                        start_frequency_select,
  input  wire logic [1:0]                  tach_divide_select,
  // Same-clock inputs
  input  wire logic [fsc_pkg::MV_W-1:0]    dc_level_mv,
  input  wire logic                        drive_zero_cross,
  // Register port
  input  wire logic [fsc_pkg::REG_AW-1:0]  reg_addr,
  input  wire logic [fsc_pkg::REG_DW-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [fsc_pkg::REG_DW-1:0]  reg_rdata,
  // Drive and status outputs
  output logic                             pwm_out,
  output logic                             drive_enable,
  output logic                             outputs_hiz,
  output logic                             short_brake,
  output logic                             tach_output,
  output logic                             lock_alarm_n,
  output logic                             regulator_enable,
  output logic      [7:0]                  phase_advance
);
  import fsc_pkg::*;

  initial begin
    if (PER_W < 10 || PER_W > REG_DW) $error("PER_W must be 10..16");
    if (RETRY_LONG >= (1 << TMR_W) || INIT_CYCLES < 1) $error("timer range");
  end

  localparam logic [PER_W-1:0] RAMP_PER = PER_W'(RAMP_PER_CYC);
  localparam logic [PER_W-1:0] DEF_PER  = PER_W'(DEFAULT_PER_CYC);
  localparam logic [TMR_W-1:0] INIT_LIM = TMR_W'(INIT_CYCLES - 1);
  localparam logic [TMR_W-1:0] SLOW_LIM = TMR_W'(HALL_SLOW);

  function automatic logic [PER_W-1:0] inc_sat(input logic [PER_W-1:0] v);
    return (&v) ? v : v + PER_W'(1);
  endfunction : inc_sat

  function automatic logic [TMR_W-1:0] tmr_inc(input logic [TMR_W-1:0] v);
    return (&v) ? v : v + TMR_W'(1);
  endfunction : tmr_inc

  // Command volts to duty in 1/256 steps; below range means stop
  function automatic logic [DUTY_W:0] dc_duty(input logic [MV_W-1:0] mv);
    logic [31:0] num;
    num = 32'(mv) * DC_GAIN - DC_OFFS_MV;
    if (32'(mv) < DC_MIN_MV) return '0;
    if (32'(mv) >= DC_MAX_MV) return (DUTY_W+1)'(DUTY_FULL);
    return (DUTY_W+1)'(num * DUTY_FULL / DC_SPAN);
  endfunction : dc_duty

  // Pin synchronisers
  logic       cmd_s;
  logic       hall_s;
  logic       sleep_s;
  logic       uvlo_s;
  logic       ps_s;
  logic       sfs_s;
  logic [1:0] tds_s;

  fsc_sync #(.W(8)) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d_in    ({speed_command_input, hall_compare, sleep_request, uvlo_active,
                phase_shift_select, start_frequency_select, tach_divide_select}),
    .q_out   ({cmd_s, hall_s, sleep_s, uvlo_s, ps_s, sfs_s, tds_s})
  );

  fsc_state_t state_reg;
  fsc_state_t state_next;
  logic       drive;

  // Register file state
  logic              ctrl_dc_reg;
  logic              ctrl_dc_next;
  logic [15:0]       sst_step_reg;
  logic [15:0]       sst_step_next;
  logic [REG_DW-1:0] rdata_reg;
  logic [REG_DW-1:0] rdata_next;

  // Speed command meter
  logic             cmd_d_reg;
  logic [PER_W-1:0] cnt_reg;
  logic [PER_W-1:0] cnt_next;
  logic [PER_W-1:0] hcnt_reg;
  logic [PER_W-1:0] hcnt_next;
  logic [PER_W-1:0] period_reg;
  logic [PER_W-1:0] period_next;
  logic [PER_W-1:0] duty_reg;
  logic [PER_W-1:0] duty_next;
  logic             seen_reg;
  logic             seen_next;
  logic             full_reg;
  logic             full_next;
  logic             zero_reg;
  logic             zero_next;
  logic [PER_W+2:0] per7;

  assign per7 = {3'h0, period_reg} * (PER_W+3)'(FULL_DUTY_PERIODS);

  // Period and high time counted every clock, finer than the 40 ns grid
  always_comb begin
    cnt_next    = inc_sat(cnt_reg);
    hcnt_next   = hcnt_reg;
    period_next = period_reg;
    duty_next   = duty_reg;
    seen_next   = seen_reg;
    full_next   = full_reg;
    zero_next   = zero_reg;
    if (cmd_s && !cmd_d_reg) begin
      if (seen_reg) begin
        period_next = inc_sat(cnt_reg); // R4
        duty_next   = hcnt_reg;
      end
      seen_next = 1'b1;
      full_next = 1'b0;
      zero_next = 1'b0;
      cnt_next  = '0;
      hcnt_next = PER_W'(1); // R5
    end else begin
      if (cmd_s) hcnt_next = inc_sat(hcnt_reg);
      // No edge for seven periods: full or zero duty, period kept
      if ({3'h0, cnt_reg} >= per7 || &cnt_reg) begin // R2
        if (cmd_s) full_next = 1'b1; // R1
        else zero_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_d_reg  <= 1'b0;
      cnt_reg    <= '0;
      hcnt_reg   <= '0;
      period_reg <= DEF_PER; // R3
      duty_reg   <= '0;
      seen_reg   <= 1'b0;
      full_reg   <= 1'b0;
      zero_reg   <= 1'b1;
    end else begin
      cmd_d_reg  <= cmd_s;
      cnt_reg    <= cnt_next;
      hcnt_reg   <= hcnt_next;
      period_reg <= period_next;
      duty_reg   <= duty_next;
      seen_reg   <= seen_next;
      full_reg   <= full_next;
      zero_reg   <= zero_next;
    end
  end

  // Targets: DC level against ramp, or measured pulse command
  logic [DUTY_W:0]  dc_code;
  logic [PER_W-1:0] dc_high;
  logic [PER_W-1:0] out_per;
  logic [PER_W-1:0] tgt_high;
  logic             cmd_run;

  assign dc_code  = dc_duty(dc_level_mv); // R19
  assign dc_high  = PER_W'((32'(RAMP_PER) * 32'(dc_code)) >> DUTY_W); // R8
  assign out_per  = ctrl_dc_reg ? RAMP_PER : period_reg; // R8
  assign tgt_high = ctrl_dc_reg ? dc_high : (full_reg ? out_per : duty_reg); // R1
  assign cmd_run  = ctrl_dc_reg ? (dc_code != '0) : !zero_reg;

  // Soft start and output PWM
  logic [PER_W-1:0] soft_reg;
  logic [PER_W-1:0] soft_next;
  logic [15:0]      step_reg;
  logic [15:0]      step_next;
  logic             sdone_reg;
  logic             sdone_next;
  logic [PER_W-1:0] pcnt_reg;
  logic [PER_W-1:0] pcnt_next;
  logic             pwm_reg;
  logic             pwm_next;
  logic [PER_W-1:0] high_app;

  // One more high clock per ramp step; a long step risks lock trips
  always_comb begin
    soft_next  = soft_reg;
    step_next  = step_reg;
    sdone_next = sdone_reg | (sst_step_reg == '0) | (soft_reg >= tgt_high); // R17
    if (!drive) begin
      soft_next  = '0;
      step_next  = '0;
      sdone_next = 1'b0;
    end else if (!sdone_reg) begin
      if (step_reg >= sst_step_reg - 16'h1) begin // R22
        step_next = '0;
        soft_next = inc_sat(soft_reg); // R16
      end else begin
        step_next = step_reg + 16'h1; // R18
      end
    end
    high_app  = sdone_reg ? tgt_high : soft_reg;
    pcnt_next = (pcnt_reg >= out_per - PER_W'(1)) ? '0 : pcnt_reg + PER_W'(1);
    pwm_next  = drive && (pcnt_reg < high_app);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reg  <= '0;
      step_reg  <= '0;
      sdone_reg <= 1'b0;
      pcnt_reg  <= '0;
      pwm_reg   <= 1'b0;
    end else begin
      soft_reg  <= soft_next;
      step_reg  <= step_next;
      sdone_reg <= sdone_next;
      pcnt_reg  <= pcnt_next;
      pwm_reg   <= pwm_next;
    end
  end

  // Hall edges, tach divider, phase trim
  logic             hall_d_reg;
  logic [TMR_W-1:0] age_reg;
  logic [TMR_W-1:0] age_next;
  logic [TMR_W-1:0] lhalf_reg;
  logic [TMR_W-1:0] lhalf_next;
  logic [2:0]       half_reg;
  logic [2:0]       half_next;
  logic [2:0]       rises_reg;
  logic [2:0]       rises_next;
  logic             tach_reg;
  logic             tach_next;
  logic             zc_reg;
  logic             zc_next;
  logic [7:0]       adv_reg;
  logic [7:0]       adv_next;
  logic             hall_edge;
  logic             hall_rise;
  logic             tach_en;
  logic             fast;
  logic [2:0]       div_n;

  assign hall_edge = hall_s ^ hall_d_reg;
  assign hall_rise = hall_s & ~hall_d_reg;
  assign tach_en   = (state_reg == ST_RUN) || (state_reg == ST_STOP); // R14
  assign fast      = (age_reg < SLOW_LIM) && (lhalf_reg < SLOW_LIM); // R15
  assign div_n     = (tds_s == TDIV_SEL_1) ? TDIV_N_1 :
                     (tds_s == TDIV_SEL_2) ? TDIV_N_2 : TDIV_N_3;

  always_comb begin
    age_next   = hall_edge ? '0 : tmr_inc(age_reg);
    lhalf_next = hall_edge ? age_reg : lhalf_reg;
    half_next  = half_reg;
    // Half-cycles counted modulo twice the divide ratio
    if (!tach_en) half_next = '0;
    else if (hall_edge) begin
      half_next = (half_reg >= 3'({div_n[1:0], 1'b0} - 3'h1)) ? '0 : half_reg + 3'h1; // R9
    end
    tach_next  = tach_en && (half_reg < div_n); // R9
    rises_next = (state_reg != ST_START) ? '0 :
                 (hall_rise && rises_reg < 3'(START_HALL_CYC)) ? rises_reg + 3'h1 : rises_reg;
    zc_next    = (hall_s == 1'b0 && hall_edge) ? 1'b0 : (zc_reg | drive_zero_cross);
    adv_next   = adv_reg;
    if (ps_s) adv_next = '0; // R11
    else if (hall_rise && state_reg == ST_RUN) begin
      // Crossing before the Hall rise means drive leads: back off
      if (zc_reg) adv_next = (adv_reg == '0) ? adv_reg : adv_reg - 8'h1; // R10
      else adv_next = (&adv_reg) ? adv_reg : adv_reg + 8'h1; // R10
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hall_d_reg <= 1'b0;
      age_reg    <= '0;
      lhalf_reg  <= '1;
      half_reg   <= '0;
      rises_reg  <= '0;
      tach_reg   <= 1'b0;
      zc_reg     <= 1'b0;
      adv_reg    <= '0;
    end else begin
      hall_d_reg <= hall_s;
      age_reg    <= age_next;
      lhalf_reg  <= lhalf_next;
      half_reg   <= half_next;
      rises_reg  <= rises_next;
      tach_reg   <= tach_next;
      zc_reg     <= zc_next;
      adv_reg    <= adv_next;
    end
  end

  // Start/stop sequencer
  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] tmr_next;
  logic [TMR_W-1:0] lock_lim;
  logic [TMR_W-1:0] retry_lim;

  assign lock_lim  = sfs_s ? TMR_W'(LOCK_LONG) : TMR_W'(LOCK_SHORT);
  assign retry_lim = sfs_s ? TMR_W'(RETRY_LONG) : TMR_W'(RETRY_SHORT);
  assign drive     = (state_reg == ST_START) || (state_reg == ST_RUN);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SLEEP: if (!sleep_s) state_next = ST_INIT; // R13
      ST_INIT:  if (tmr_reg >= INIT_LIM) state_next = ST_IDLE; // R12
      ST_IDLE:  if (cmd_run) state_next = ST_START;
      ST_START: begin
        if (!cmd_run) state_next = ST_STOP;
        else if (rises_reg >= 3'(START_HALL_CYC)) state_next = ST_RUN; // R14
        else if (age_reg >= lock_lim) state_next = ST_LOCK; // R21
      end
      ST_RUN: begin
        if (!cmd_run) state_next = ST_STOP; // R15
        else if (age_reg >= lock_lim) state_next = ST_LOCK; // R21
      end
      ST_STOP:  if (cmd_run) state_next = ST_START;
      ST_LOCK: begin
        if (hall_edge || tmr_reg >= retry_lim) state_next = cmd_run ? ST_START : ST_IDLE;
      end
      default:  state_next = ST_INIT;
    endcase
    // Sleep overrides all, lockout restarts initialisation
    if (sleep_s) state_next = ST_SLEEP; // R20
    else if (uvlo_s) state_next = ST_INIT; // R12
    tmr_next = (state_next != state_reg || (uvlo_s && !sleep_s)) ? '0 : tmr_inc(tmr_reg);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_INIT;
      tmr_reg   <= '0;
    end else begin
      state_reg <= state_next;
      tmr_reg   <= tmr_next;
    end
  end

  // Register port: writes steer mode and ramp, reads show state
  always_comb begin
    ctrl_dc_next  = ctrl_dc_reg;
    sst_step_next = sst_step_reg;
    rdata_next    = '0;
    if (reg_wr && reg_addr == ADDR_CTRL) ctrl_dc_next = reg_wdata[CTRL_DC];
    if (reg_wr && reg_addr == ADDR_SST) sst_step_next = reg_wdata;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: rdata_next[CTRL_DC] = ctrl_dc_reg;
        ADDR_SST:  rdata_next = sst_step_reg;
        ADDR_STAT: begin
          rdata_next[6:0]       = state_reg;
          rdata_next[STAT_FULL] = full_reg;
          rdata_next[STAT_ZERO] = zero_reg;
          rdata_next[STAT_FAST] = fast;
          rdata_next[STAT_SEEN] = seen_reg;
        end
        ADDR_PER:  rdata_next = REG_DW'(period_reg);
        ADDR_DUTY: rdata_next = REG_DW'(duty_reg);
        ADDR_ADV:  rdata_next[7:0] = adv_reg;
        default:   rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_dc_reg  <= 1'b0;
      sst_step_reg <= SST_RST;
      rdata_reg    <= '0;
    end else begin
      ctrl_dc_reg  <= ctrl_dc_next;
      sst_step_reg <= sst_step_next;
      rdata_reg    <= rdata_next;
    end
  end

  // Output decode; stopped states float except slow stop and lock
  assign reg_rdata        = rdata_reg;
  assign pwm_out          = pwm_reg;
  assign tach_output      = tach_reg;
  assign phase_advance    = adv_reg;
  assign drive_enable     = drive;
  assign short_brake      = ((state_reg == ST_STOP) && !fast) || (state_reg == ST_LOCK); // R15
  assign outputs_hiz      = !drive && !short_brake; // R20
  assign lock_alarm_n     = (state_reg != ST_LOCK); // R21
  assign regulator_enable = (state_reg != ST_SLEEP); // R20
endmodule : fsc_core
`default_nettype wire

// File: rtl/fsc_pkg.sv
// Constants and state codes of the fan control core.
// Assumes one 40 MHz clock and that all analog stages sit outside.
//
// Summary of operation
// R1 - Full duty holds last measured command period
// R2 - Full duty seen after seven held periods
// R3 - Full duty at start: default 58 kHz
// R4 - Output then tracks measured command frequency
// R5 - Command sampled finely; short pulses may vanish
// R6 - Host keeps command low phases 500 ns
// R7 - Host preferably holds command low to stop
// R8 - DC mode compares level against ramp
// R9 - Tach cycle per one, two, three Hall
// R10 - Phase select low: automatic phase correction
// R11 - Phase select high: zero phase advance
// R12 - 2 ms initialisation after supply lockout release
// R13 - 2 ms initialisation after sleep exit
// R14 - Start-up four Hall cycles, tach suppressed
// R15 - Stop: float above 7 Hz, else brake
// R16 - Soft-start duty grows with elapsed time
// R17 - Soft start ends at commanded duty
// R18 - Long soft start may trip lock detection
// R19 - DC duty from command voltage, 1-4 V
// R20 - Sleep: outputs off, regulator off, protections stop
// R21 - No Hall edge 0.5/1 s: brake, alarm
// R22 - Soft-start ramp is a counted step
package fsc_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned OSC_HZ            = 25_000_000;
  localparam int unsigned INIT_MS           = 2;
  localparam int unsigned INIT_CYC          = CLK_HZ / 1000 * INIT_MS;
  localparam int unsigned DEFAULT_PWM_HZ    = 58_000;
  localparam int unsigned DEFAULT_PER_CYC   = CLK_HZ / DEFAULT_PWM_HZ;
  localparam int unsigned FULL_DUTY_PERIODS = 7;
  localparam int unsigned START_HALL_CYC    = 4;
  localparam int unsigned STOP_HALL_HZ      = 7;
  localparam int unsigned HALL_SLOW_CYC     = CLK_HZ / (2 * STOP_HALL_HZ);
  localparam int unsigned LOCK_SHORT_MS     = 500;
  localparam int unsigned LOCK_LONG_MS      = 1000;
  localparam int unsigned RETRY_SHORT_MS    = 5000;
  localparam int unsigned RETRY_LONG_MS     = 10000;
  localparam int unsigned LOCK_SHORT_CYC    = CLK_HZ / 1000 * LOCK_SHORT_MS;
  localparam int unsigned LOCK_LONG_CYC     = CLK_HZ / 1000 * LOCK_LONG_MS;
  localparam int unsigned RETRY_SHORT_CYC   = CLK_HZ / 1000 * RETRY_SHORT_MS;
  localparam int unsigned RETRY_LONG_CYC    = CLK_HZ / 1000 * RETRY_LONG_MS;
  localparam int unsigned RAMP_HZ           = 55_400;
  localparam int unsigned RAMP_PER_CYC      = CLK_HZ / RAMP_HZ;
  localparam int unsigned SST_HZ            = 1_130;
  localparam int unsigned SST_STEP_DEF      = OSC_HZ / SST_HZ;
  localparam int unsigned TMR_W             = 29;

  // DC command transfer: duty% * 3 = 97 * V - 88, volts in mV
  localparam int unsigned DC_GAIN    = 97;
  localparam int unsigned DC_OFFS_MV = 88_000;
  localparam int unsigned DC_SPAN    = 300_000;
  localparam int unsigned DC_MIN_MV  = 1000;
  localparam int unsigned DC_MAX_MV  = 4000;
  localparam int unsigned DUTY_W     = 8;
  localparam int unsigned DUTY_FULL  = 256;
  localparam int unsigned MV_W       = 13;

  // Tach divide select codes
  localparam logic [1:0] TDIV_SEL_1 = 2'h0;
  localparam logic [1:0] TDIV_SEL_2 = 2'h1;
  localparam logic [2:0] TDIV_N_1   = 3'h1;
  localparam logic [2:0] TDIV_N_2   = 3'h2;
  localparam logic [2:0] TDIV_N_3   = 3'h3;

  // Register port map
  localparam int unsigned REG_AW     = 4;
  localparam int unsigned REG_DW     = 16;
  localparam logic [3:0]  ADDR_CTRL  = 4'h0;
  localparam logic [3:0]  ADDR_SST   = 4'h1;
  localparam logic [3:0]  ADDR_STAT  = 4'h2;
  localparam logic [3:0]  ADDR_PER   = 4'h3;
  localparam logic [3:0]  ADDR_DUTY  = 4'h4;
  localparam logic [3:0]  ADDR_ADV   = 4'h5;
  localparam int unsigned CTRL_DC    = 0;
  localparam int unsigned STAT_FULL  = 7;
  localparam int unsigned STAT_ZERO  = 8;
  localparam int unsigned STAT_FAST  = 9;
  localparam int unsigned STAT_SEEN  = 10;
  localparam logic [15:0] SST_RST    = 16'(SST_STEP_DEF);

  // Sequencer states
  typedef enum logic [6:0] {
    ST_SLEEP = 7'h01,
    ST_INIT  = 7'h02,
    ST_IDLE  = 7'h04,
    ST_START = 7'h08,
    ST_RUN   = 7'h10,
    ST_STOP  = 7'h20,
    ST_LOCK  = 7'h40
  } fsc_state_t;

endpackage : fsc_pkg

// File: rtl/fsc_sync.sv
// Three-stage pin synchroniser; a bit changes once stages two and three agree.
// Assumes its inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module fsc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;
  logic [W-1:0] agree;

  // Stage one feeds stage two only, against metastability
  always_comb begin
    agree  = ~(s2_reg ^ s3_reg);
    q_next = (s2_reg & agree) | (q_reg & ~agree);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q_out = q_reg;
endmodule : fsc_sync
`default_nettype wire

// File: sim/fsc_core_asserts.sv
// Port checker bound into every fan control core.
// Assumes one clock and an active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module fsc_core_chk #(
  parameter int unsigned INIT_CYCLES = 80000
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Watched ports
  input wire logic        uvlo_active,
  input wire logic        phase_shift_select,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        drive_enable,
  input wire logic        outputs_hiz,
  input wire logic        short_brake,
  input wire logic        tach_output,
  input wire logic        lock_alarm_n,
  input wire logic        regulator_enable,
  input wire logic [7:0]  phase_advance
);
  logic [31:0] up_reg;
  // Cycles since reset, saturating
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) up_reg <= 32'h0;
    else if (!(&up_reg)) up_reg <= up_reg + 32'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_init_quiet: assert property (up_reg < INIT_CYCLES |-> !drive_enable && !tach_output)
    else $error("drive during init");
  chk_uvlo_float: assert property (uvlo_active [*8] |-> outputs_hiz && !drive_enable)
    else $error("drive under lockout");
  chk_sleep_off: assert property (!regulator_enable |-> outputs_hiz && !short_brake)
    else $error("outputs active in sleep");
  chk_lock_brake: assert property (!lock_alarm_n |-> short_brake && !drive_enable)
    else $error("lock without brake");
  chk_drive_only: assert property (drive_enable |-> !outputs_hiz && !short_brake)
    else $error("drive mixed with stop");
  chk_hiz_brake: assert property (!(outputs_hiz && short_brake))
    else $error("float and brake together");
  chk_adv_fixed: assert property (phase_shift_select [*8] |-> phase_advance == 8'h0)
    else $error("advance with fixed phase");
  chk_adv_step: assert property ($changed(phase_advance) |-> phase_advance == 8'h0 ||
    phase_advance - $past(phase_advance) == 8'h1 || $past(phase_advance) - phase_advance == 8'h1)
    else $error("advance jumped");
  chk_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside slot");
  cov_drive: cover property ($rose(drive_enable));
  cov_lock: cover property ($fell(lock_alarm_n));
  cov_brake: cover property ($rose(short_brake));
endmodule : fsc_core_chk
bind fsc_core fsc_core_chk #(.INIT_CYCLES(INIT_CYCLES)) i_fsc_core_chk (.*);
`default_nettype wire

// File: sim/fsc_far_model.sv
// Host speed source and Hall sensor of the fan control core.
// Assumes the bench picks command mode and rotor motion.
`timescale 1ns/1ps
`default_nettype none
module fsc_far_model #(
  parameter int unsigned HI   = 20,
  parameter int unsigned LO   = 20,
  parameter int unsigned HALF = 40
) (
  // Clock and controls
  input  wire logic       ref_clk,
  input  wire logic [1:0] cmd_mode,
  input  wire logic       hall_en,
  // Pins toward the core
  output logic            speed_command_input = 1'b0,
  output logic            hall_compare = 1'b0
);
  int unsigned cmd_cnt = 0;
  int unsigned hall_cnt = 0;
  // Command: 0 low, 1 high, else pulses; low phase 500 ns at 40 MHz
  always @(posedge ref_clk) begin
    cmd_cnt <= (cmd_cnt + 1 >= HI + LO) ? 0 : cmd_cnt + 1;
    case (cmd_mode)
      2'h0: speed_command_input <= 1'b0;
      2'h1: speed_command_input <= 1'b1;
      default: speed_command_input <= (cmd_cnt < HI);
    endcase
  end
  // Rotor turns at a fixed rate or holds its level
  always @(posedge ref_clk) begin
    if (hall_en) begin
      hall_cnt <= (hall_cnt + 1 >= HALF) ? 0 : hall_cnt + 1;
      if (hall_cnt + 1 >= HALF) hall_compare <= ~hall_compare;
    end
  end
endmodule : fsc_far_model
`default_nettype wire

// File: sim/fsc_core_tb.sv
// Bench of the fan control core over its register port.
// Assumes the far model drives command and Hall pins.
`timescale 1ns/1ps
`default_nettype none
module fsc_core_tb;
  import fsc_pkg::*;
  logic ref_clk, rst_n, hall_en, sleep_request, uvlo_active, phase_shift_select;
  logic reg_wr, reg_rd, pwm_out, drive_enable, outputs_hiz, short_brake;
  logic tach_output, lock_alarm_n, regulator_enable;
  wire logic speed_command_input, hall_compare;
  logic [1:0]  cmd_mode, tach_divide_select;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d, a;
  logic [7:0]  phase_advance;
  int num_errors = 0;
  int checks = 0;
  int t, c;
  fsc_far_model i_fsc_far_model (.*);
  // Short counts keep the run brief
  fsc_core #(.INIT_CYCLES(50), .LOCK_SHORT(300), .LOCK_LONG(600), .RETRY_SHORT(2000),
    .RETRY_LONG(4000), .HALL_SLOW(100)) i_fsc_core (.*, .start_frequency_select(1'b0),
    .dc_level_mv(13'h0), .drive_zero_cross(1'b0));
  task automatic summarize;
    $display("num_errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp16
  task automatic wr(input logic [3:0] ad, input logic [15:0] wd);
    @(posedge ref_clk) begin reg_wr <= 1'b1; reg_addr <= ad; reg_wdata <= wd; end
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask : wr
  // Data taken at the edge ending its slot
  task automatic rd(input logic [3:0] ad, output logic [15:0] rv);
    @(posedge ref_clk) begin reg_rd <= 1'b1; reg_addr <= ad; end
    @(posedge ref_clk) reg_rd <= 1'b0;
    @(posedge ref_clk) rv = reg_rdata;
  endtask : rd
  task automatic chk(input logic [3:0] ad, input logic [15:0] e);
    logic [15:0] rv;
    rd(ad, rv);
    cmp16(rv, e);
  endtask : chk
  // Bounded wait: 0 drive, 1 brake, 2 lock alarm, 3 sleep, 4 float
  task automatic await(input int s, input int n);
    int i;
    logic [4:0] v;
    for (i = 0; i < n; i++) begin
      @(posedge ref_clk);
      v = {outputs_hiz, ~regulator_enable, ~lock_alarm_n, short_brake, drive_enable};
      if (v[s] === 1'b1) break;
    end
    checks++;
    if (i == n) begin
      num_errors++;
      summarize();
    end
  endtask : await
  // Bounded wait on 0 tach, 1 Hall, 2 command pin
  task automatic till(input int h, input logic v, output int n);
    for (n = 0; n < 2000 && (h == 2 ? speed_command_input : h == 1 ? hall_compare :
         tach_output) !== v; n++) @(posedge ref_clk);
    if (n == 2000) begin
      num_errors++;
      summarize();
    end
  endtask : till
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    summarize();
  end
  initial begin
    {rst_n, hall_en, sleep_request, uvlo_active, phase_shift_select, reg_wr, reg_rd} = 7'h0;
    {cmd_mode, tach_divide_select, reg_addr, reg_wdata} = 24'h0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(ADDR_STAT, 16'h0102);
    chk(ADDR_SST, SST_RST);
    chk(ADDR_PER, 16'h02b1);
    wr(4'hf, 16'hffff);
    chk(4'hf, 16'h0);
    wr(ADDR_STAT, 16'h0);
    chk(ADDR_STAT, 16'h0102);
    wr(ADDR_CTRL, 16'h1);
    chk(ADDR_CTRL, 16'h1);
    wr(ADDR_CTRL, 16'h0);
    wr(ADDR_SST, 16'h0);
    chk(ADDR_SST, 16'h0);
    // Command pulses already run while init must ignore them
    cmd_mode <= 2'h2;
    await(0, 300);
    repeat (80) @(posedge ref_clk);
    chk(ADDR_PER, 16'h0028);
    chk(ADDR_DUTY, 16'h0014);
    hall_en <= 1'b1;
    t = 0;
    repeat (240) @(posedge ref_clk) t += (tach_output !== 1'b0);
    cmp16(16'(t), 16'h0);
    for (int s = 0; s < 4; s++) begin
      tach_divide_select <= 2'(s);
      till(0, 1, c);
      till(0, 0, c);
      till(0, 1, c);
      till(0, 0, t);
      till(0, 1, c);
      cmp16(16'(t + c), 16'((s > 2 ? 3 : s + 1) * 80));
    end
    till(1, 0, c);
    till(1, 1, c);
    repeat (10) @(posedge ref_clk);
    rd(ADDR_ADV, a);
    till(1, 0, c);
    till(1, 1, c);
    repeat (10) @(posedge ref_clk);
    chk(ADDR_ADV, a + 16'h1);
    phase_shift_select <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk(ADDR_ADV, 16'h0);
    till(2, 0, c);
    till(2, 1, c);
    cmd_mode <= 2'h1;
    repeat (200) @(posedge ref_clk);
    rd(ADDR_STAT, d);
    cmp16(16'(d[STAT_FULL]), 16'h0);
    repeat (130) @(posedge ref_clk);
    rd(ADDR_STAT, d);
    cmp16(16'(d[STAT_FULL]), 16'h1);
    chk(ADDR_PER, 16'h0028);
    cmd_mode <= 2'h0;
    await(4, 400);
    cmp16(16'(short_brake), 16'h0);
    hall_en <= 1'b0;
    await(1, 400);
    cmd_mode <= 2'h2;
    await(2, 1000);
    sleep_request <= 1'b1;
    await(3, 20);
    rd(ADDR_STAT, d);
    cmp16(16'(d[6:0]), 16'h1);
    sleep_request <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rd(ADDR_STAT, d);
    cmp16(16'(d[6:0]), 16'h2);
    repeat (32) @(posedge ref_clk);
    cmp16(16'(drive_enable), 16'h0);
    await(0, 200);
    uvlo_active <= 1'b1;
    repeat (12) @(posedge ref_clk);
    cmp16(16'(outputs_hiz), 16'h1);
    uvlo_active <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(ADDR_STAT, 16'h0102);
    summarize();
  end
endmodule : fsc_core_tb
`default_nettype wire
